// ===== hw/ucr_params.svh
// constants for the uart channel register map and loopback block
// assumes inclusion by bare name from the package and the design
`ifndef UCR_PARAMS_SVH
`define UCR_PARAMS_SVH

// register offsets on the three address lines
`define UCR_OFS_0 3'h0
`define UCR_OFS_1 3'h1
`define UCR_OFS_2 3'h2
`define UCR_OFS_3 3'h3
`define UCR_OFS_4 3'h4
`define UCR_OFS_5 3'h5
`define UCR_OFS_6 3'h6
`define UCR_OFS_7 3'h7

// line control value that opens the enhanced registers
`define UCR_ENH_KEY 8'hbf
`define UCR_ZERO_BYTE 8'h00

// field positions
`define UCR_LCR_DLAB 7
`define UCR_MCR_DTR 0
`define UCR_MCR_RTS 1
`define UCR_MCR_OP1 2
`define UCR_MCR_OP2 3
`define UCR_MCR_LOOP 4
`define UCR_FEATURE_CONTROL_SWAP 6

// reset values
`define UCR_RST_BYTE 8'h00
`define UCR_RST_DIV 8'h00
`define UCR_RST_MODEM 4'h0

`endif

// ===== hw/ucr_pkg.sv
// types for the uart channel register map and loopback block
// assumes the params header sits beside this file
`default_nettype none
package ucr_pkg;
    `include "ucr_params.svh"

    // host access to one channel, already channel-selected
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ucr_req_t;

    // modem inputs, active low as on the pins
    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ucr_modem_pins_t;

    // status bytes supplied by the rest of the channel
    typedef struct packed {
        logic [7:0] rx_byte;
        logic [7:0] int_status;
        logic [7:0] line_status;
        logic [7:0] fifo_level;
        logic [7:0] fifo_level_enh;
        logic [7:0] fifo_status;
    } ucr_stat_t;

    // configuration held here and used by the rest of the channel
    typedef struct packed {
        logic [15:0] divisor;
        logic [7:0] interrupt_enable;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] feature_control;
        logic [7:0] enhanced_function;
        logic [7:0] resume_char1;
        logic [7:0] resume_char2;
        logic [7:0] stop_char1;
        logic [7:0] stop_char2;
        logic loopback;
    } ucr_cfg_t;

    // register that an access at the current offset reaches
    typedef enum logic [4:0] {
        UCR_T_NONE,
        UCR_T_HOLD,
        UCR_T_DLL,
        UCR_T_DLM,
        UCR_T_IER,
        UCR_T_ISR_FCR,
        UCR_T_LCR,
        UCR_T_MCR,
        UCR_T_LSR,
        UCR_T_MSR,
        UCR_T_SPR,
        UCR_T_FIFO_LEVEL_COUNT_ENHANCED_MODE_SELECT,
        UCR_T_TRG_FC,
        UCR_T_FEATURE_CONTROL,
        UCR_T_EFR,
        UCR_T_XON1,
        UCR_T_XON2,
        UCR_T_XOFF1,
        UCR_T_XOFF2
    } ucr_target_t;
endpackage
`default_nettype wire

// ===== hw/ucr_regmap.sv
// per-channel register decode of a quad uart with internal loopback
// assumes host strobes are synchronous to mclk and already channel-selected
// Function
// - modem control bit 4 enables loopback
// - loopback routes transmit shift into receiver
// - loopback: tx mark, rts/dtr deasserted
// - loopback ignores external modem inputs
// - own register set per channel, offset-selected
// - offset 0: receive/transmit holding, dlab clear
// - dlab set, not key: divisor bytes
// - zero divisor reads revision and id
// - key value exposes enhanced registers 0-2 and 4-7
// - enhanced 0 trigger/count, 1 feature, 2 function
// - enhanced 4-7 resume and stop characters
// - offset 2 status/fifo control, 1 enable
// - line control at 3 always accessible
// - 4 modem control, 5/6 status read-only
// - offset 7 scratch or level/mode by swap
// - status select pin low reads fifo status
// - modem status: states high, changes low
`timescale 1ns/10ps
`default_nettype none
`include "ucr_params.svh"
module ucr_regmap #(
    parameter int DATA_W = 8,
    parameter logic [7:0] REV_CODE = 8'h01, // arbitrary value
    parameter logic [7:0] DEV_ID = 8'h5a    // arbitrary value
) (
    input wire logic mclk,
    input wire logic rst,
    input wire ucr_pkg::ucr_req_t req,
    output logic [7:0] rdata,
    input wire logic fifo_status_select_pin_n,
    input wire ucr_pkg::ucr_stat_t stat,
    output ucr_pkg::ucr_cfg_t cfg,
    output logic hold_wr,
    output logic fifo_control_wr,
    output logic trigger_wr,
    output logic mode_select_wr,
    output logic [7:0] wr_data,
    output logic rx_pop,
    output logic line_status_rd,
    input wire logic tx_shift_out,
    output logic rx_shift_in,
    output logic tx_pin,
    input wire logic rx_pin,
    input wire ucr_pkg::ucr_modem_pins_t modem_pins,
    output logic rts_n,
    output logic dtr_n,
    output logic op1_n,
    output logic op2_n
);
    import ucr_pkg::*;

    // the byte lanes below are fixed at eight bits
    if (DATA_W != 8) begin : g_bad_width
        $error("ucr_regmap serves 8-bit data only");
    end

    // every register below belongs to this one channel
    logic [7:0] dll_q;
    logic [7:0] dlm_q;
    logic [7:0] ier_q;
    logic [7:0] lcr_q;
    logic [7:0] mcr_q;
    logic [7:0] feature_control_q;
    logic [7:0] efr_q;
    logic [7:0] spr_q;
    logic [7:0] xon1_q;
    logic [7:0] xon2_q;
    logic [7:0] xoff1_q;
    logic [7:0] xoff2_q;
    logic [7:0] rdata_q;
    logic [7:0] wr_data_q;
    logic hold_wr_q;
    logic fifo_control_wr_q;
    logic trigger_wr_q;
    logic mode_select_wr_q;
    logic rx_pop_q;
    logic line_status_rd_q;
    logic [7:0] mcr_d;
    logic rts_n_q;
    logic dtr_n_q;
    logic op1_n_q;
    logic op2_n_q;
    logic [3:0] modem_prev_q;
    logic [3:0] modem_delta_q;
    logic [3:0] modem_now;
    logic [3:0] modem_delta_d;
    logic loop;
    logic dlab;
    logic enh;
    logic div_zero;
    logic rd_normal;
    logic msr_read;
    logic [7:0] rd_mux;
    ucr_target_t tgt;

    assign loop = mcr_q[`UCR_MCR_LOOP];
    assign dlab = lcr_q[`UCR_LCR_DLAB];
    assign enh = (lcr_q == `UCR_ENH_KEY);
    assign div_zero = (dll_q == `UCR_ZERO_BYTE) && (dlm_q == `UCR_ZERO_BYTE);

    // address decode; the key value beats the divisor latch bit
    always_comb begin
        tgt = UCR_T_NONE;
        case (req.addr)
            `UCR_OFS_0: begin
                if (enh) begin
                    tgt = UCR_T_TRG_FC;
                end else if (dlab) begin
                    tgt = UCR_T_DLL;
                end else begin
                    tgt = UCR_T_HOLD;
                end
            end
            `UCR_OFS_1: begin
                if (enh) begin
                    tgt = UCR_T_FEATURE_CONTROL;
                end else if (dlab) begin
                    tgt = UCR_T_DLM;
                end else begin
                    tgt = UCR_T_IER;
                end
            end
            `UCR_OFS_2: begin
                if (enh) begin
                    tgt = UCR_T_EFR;
                end else if (!dlab) begin
                    tgt = UCR_T_ISR_FCR;
                end
            end
            `UCR_OFS_3: begin
                tgt = UCR_T_LCR;
            end
            `UCR_OFS_4: begin
                if (enh) begin
                    tgt = UCR_T_XON1;
                end else if (!dlab) begin
                    tgt = UCR_T_MCR;
                end
            end
            `UCR_OFS_5: begin
                if (enh) begin
                    tgt = UCR_T_XON2;
                end else if (!dlab) begin
                    tgt = UCR_T_LSR;
                end
            end
            `UCR_OFS_6: begin
                if (enh) begin
                    tgt = UCR_T_XOFF1;
                end else if (!dlab) begin
                    tgt = UCR_T_MSR;
                end
            end
            `UCR_OFS_7: begin
                if (enh) begin
                    tgt = UCR_T_XOFF2;
                end else if (!dlab) begin
                    if (feature_control_q[`UCR_FEATURE_CONTROL_SWAP]) begin
                        tgt = UCR_T_FIFO_LEVEL_COUNT_ENHANCED_MODE_SELECT;
                    end else begin
                        tgt = UCR_T_SPR;
                    end
                end
            end
            default: begin
                tgt = UCR_T_NONE;
            end
        endcase
    end

    // a low select pin steals every read, so no read side effect fires
    assign rd_normal = req.rd && fifo_status_select_pin_n;
    assign msr_read = rd_normal && (tgt == UCR_T_MSR);

    always_comb begin
        rd_mux = `UCR_ZERO_BYTE;
        case (tgt)
            UCR_T_HOLD: rd_mux = stat.rx_byte;
            UCR_T_DLL: rd_mux = div_zero ? REV_CODE : dll_q;
            UCR_T_DLM: rd_mux = div_zero ? DEV_ID : dlm_q;
            UCR_T_IER: rd_mux = ier_q;
            UCR_T_ISR_FCR: rd_mux = stat.int_status;
            UCR_T_LCR: rd_mux = lcr_q;
            UCR_T_MCR: rd_mux = mcr_q;
            UCR_T_LSR: rd_mux = stat.line_status;
            UCR_T_MSR: rd_mux = {modem_now, modem_delta_q};
            UCR_T_SPR: rd_mux = spr_q;
            UCR_T_FIFO_LEVEL_COUNT_ENHANCED_MODE_SELECT: rd_mux = stat.fifo_level;
            UCR_T_TRG_FC: rd_mux = stat.fifo_level_enh;
            UCR_T_FEATURE_CONTROL: rd_mux = feature_control_q;
            UCR_T_EFR: rd_mux = efr_q;
            UCR_T_XON1: rd_mux = xon1_q;
            UCR_T_XON2: rd_mux = xon2_q;
            UCR_T_XOFF1: rd_mux = xoff1_q;
            UCR_T_XOFF2: rd_mux = xoff2_q;
            default: rd_mux = `UCR_ZERO_BYTE;
        endcase
    end

    // read data held until the next read
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= `UCR_RST_BYTE;
        end else if (req.rd) begin
            if (!fifo_status_select_pin_n) begin
                rdata_q <= stat.fifo_status;
            end else begin
                rdata_q <= rd_mux;
            end
        end
    end

    // read side effects only where the location is readable
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_pop_q <= 1'b0;
            line_status_rd_q <= 1'b0;
        end else begin
            rx_pop_q <= rd_normal && (tgt == UCR_T_HOLD);
            line_status_rd_q <= rd_normal && (tgt == UCR_T_LSR);
        end
    end

    // storage writes; unmatched targets fall through untouched
    always_ff @(posedge mclk) begin
        if (rst) begin
            dll_q <= `UCR_RST_DIV;
            dlm_q <= `UCR_RST_DIV;
            ier_q <= `UCR_RST_BYTE;
            lcr_q <= `UCR_RST_BYTE;
            mcr_q <= `UCR_RST_BYTE;
            feature_control_q <= `UCR_RST_BYTE;
            efr_q <= `UCR_RST_BYTE;
            spr_q <= `UCR_RST_BYTE;
            xon1_q <= `UCR_RST_BYTE;
            xon2_q <= `UCR_RST_BYTE;
            xoff1_q <= `UCR_RST_BYTE;
            xoff2_q <= `UCR_RST_BYTE;
        end else if (req.wr) begin
            case (tgt)
                UCR_T_DLL: dll_q <= req.wdata;
                UCR_T_DLM: dlm_q <= req.wdata;
                UCR_T_IER: ier_q <= req.wdata;
                UCR_T_LCR: lcr_q <= req.wdata;
                UCR_T_MCR: mcr_q <= req.wdata;
                UCR_T_SPR: spr_q <= req.wdata;
                UCR_T_FEATURE_CONTROL: feature_control_q <= req.wdata;
                UCR_T_EFR: efr_q <= req.wdata;
                UCR_T_XON1: xon1_q <= req.wdata;
                UCR_T_XON2: xon2_q <= req.wdata;
                UCR_T_XOFF1: xoff1_q <= req.wdata;
                UCR_T_XOFF2: xoff2_q <= req.wdata;
                default: begin
                end
            endcase
        end
    end

    // write strobes for registers that live outside this block
    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_wr_q <= 1'b0;
            fifo_control_wr_q <= 1'b0;
            trigger_wr_q <= 1'b0;
            mode_select_wr_q <= 1'b0;
            wr_data_q <= `UCR_RST_BYTE;
        end else begin
            hold_wr_q <= req.wr && (tgt == UCR_T_HOLD);
            fifo_control_wr_q <= req.wr && (tgt == UCR_T_ISR_FCR);
            trigger_wr_q <= req.wr && (tgt == UCR_T_TRG_FC);
            mode_select_wr_q <= req.wr && (tgt == UCR_T_FIFO_LEVEL_COUNT_ENHANCED_MODE_SELECT);
            if (req.wr) begin
                wr_data_q <= req.wdata;
            end
        end
    end

    // modem inputs as active-high states, cd ri dsr cts order
    always_comb begin
        if (loop) begin
            // pins are not looked at while looped
            modem_now = {mcr_q[`UCR_MCR_OP2], mcr_q[`UCR_MCR_OP1],
                         mcr_q[`UCR_MCR_DTR], mcr_q[`UCR_MCR_RTS]};
        end else begin
            modem_now = ~{modem_pins.cd_n, modem_pins.ri_n,
                          modem_pins.dsr_n, modem_pins.cts_n};
        end
    end

    // ri flags only its trailing edge, the others any change
    always_comb begin
        modem_delta_d = modem_delta_q;
        if (msr_read) begin
            modem_delta_d = `UCR_RST_MODEM;
        end
        // set after clear so a change in the read cycle survives
        modem_delta_d[3] = modem_delta_d[3] | (modem_now[3] ^ modem_prev_q[3]);
        modem_delta_d[2] = modem_delta_d[2] | (modem_prev_q[2] & ~modem_now[2]);
        modem_delta_d[1] = modem_delta_d[1] | (modem_now[1] ^ modem_prev_q[1]);
        modem_delta_d[0] = modem_delta_d[0] | (modem_now[0] ^ modem_prev_q[0]);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            modem_prev_q <= `UCR_RST_MODEM;
            modem_delta_q <= `UCR_RST_MODEM;
        end else begin
            modem_prev_q <= modem_now;
            modem_delta_q <= modem_delta_d;
        end
    end

    // serial paths stay combinational so loopback timing matches the line
    assign rx_shift_in = loop ? tx_shift_out : rx_pin;
    assign tx_pin = loop ? 1'b1 : tx_shift_out;
    // rx_pin is expected to idle high across loopback
    // next modem control, so the pin flops match the register each cycle
    assign mcr_d = (req.wr && (tgt == UCR_T_MCR)) ? req.wdata : mcr_q;

    // modem pins straight from flops, free of decode glitches
    always_ff @(posedge mclk) begin
        if (rst) begin
            rts_n_q <= 1'b1;
            dtr_n_q <= 1'b1;
            op1_n_q <= 1'b1;
            op2_n_q <= 1'b1;
        end else if (mcr_d[`UCR_MCR_LOOP]) begin
            // all four held deasserted while looped
            rts_n_q <= 1'b1;
            dtr_n_q <= 1'b1;
            op1_n_q <= 1'b1;
            op2_n_q <= 1'b1;
        end else begin
            rts_n_q <= ~mcr_d[`UCR_MCR_RTS];
            dtr_n_q <= ~mcr_d[`UCR_MCR_DTR];
            op1_n_q <= ~mcr_d[`UCR_MCR_OP1];
            op2_n_q <= ~mcr_d[`UCR_MCR_OP2];
        end
    end

    assign rts_n = rts_n_q;
    assign dtr_n = dtr_n_q;
    assign op1_n = op1_n_q;
    assign op2_n = op2_n_q;

    assign rdata = rdata_q;
    assign hold_wr = hold_wr_q;
    assign fifo_control_wr = fifo_control_wr_q;
    assign trigger_wr = trigger_wr_q;
    assign mode_select_wr = mode_select_wr_q;
    assign wr_data = wr_data_q;
    assign rx_pop = rx_pop_q;
    assign line_status_rd = line_status_rd_q;

    assign cfg.divisor = {dlm_q, dll_q};
    assign cfg.interrupt_enable = ier_q;
    assign cfg.line_control = lcr_q;
    assign cfg.modem_control = mcr_q;
    assign cfg.feature_control = feature_control_q;
    assign cfg.enhanced_function = efr_q;
    assign cfg.resume_char1 = xon1_q;
    assign cfg.resume_char2 = xon2_q;
    assign cfg.stop_char1 = xoff1_q;
    assign cfg.stop_char2 = xoff2_q;
    assign cfg.loopback = loop;
endmodule
`default_nettype wire

// ===== tb/ucr_regmap_assertions.sv
// assertions on the ports of the uart channel register map
// assumes one clock domain and a bind onto every ucr_regmap
`timescale 1ns/10ps
`default_nettype none
module ucr_regmap_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire ucr_pkg::ucr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic fifo_status_select_pin_n,
    input wire ucr_pkg::ucr_stat_t stat,
    input wire ucr_pkg::ucr_cfg_t cfg,
    input wire logic hold_wr,
    input wire logic [7:0] wr_data,
    input wire logic rx_pop,
    input wire logic tx_shift_out,
    input wire logic rx_shift_in,
    input wire logic tx_pin,
    input wire logic rx_pin,
    input wire logic rts_n,
    input wire logic dtr_n
);
    import ucr_pkg::*;
    logic norm;
    logic [3:0] loop_ms;
    logic sel_n;
    assign norm = !cfg.line_control[7];
    assign sel_n = fifo_status_select_pin_n;
    // looped modem status order: op2, op1, dtr, rts
    assign loop_ms = {cfg.modem_control[3:2], cfg.modem_control[0],
        cfg.modem_control[1]};

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_loop_enter: assert property (req.wr && req.addr == 3'h4 && norm
        |=> cfg.loopback == $past(req.wdata[4])) else $error("loop bit");
    a_loop_route: assert property (cfg.loopback
        |-> rx_shift_in == tx_shift_out) else $error("loop route");
    a_norm_route: assert property (!cfg.loopback
        |-> rx_shift_in == rx_pin && tx_pin == tx_shift_out)
        else $error("normal route");
    a_loop_mark: assert property (cfg.loopback
        |-> tx_pin && rts_n && dtr_n) else $error("loop outputs");
    a_lcr_write: assert property (req.wr && req.addr == 3'h3
        |=> cfg.line_control == $past(req.wdata)) else $error("lcr write");
    a_hold_write: assert property (req.wr && req.addr == 3'h0 && norm
        |=> hold_wr && wr_data == $past(req.wdata)) else $error("hold wr");
    a_hold_read: assert property (req.rd && req.addr == 3'h0 && norm
        && sel_n |=> rx_pop && rdata == $past(stat.rx_byte))
        else $error("hold rd");
    a_fifo_status_summary_read: assert property (req.rd && !sel_n
        |=> rdata == $past(stat.fifo_status) && !rx_pop)
        else $error("fifo_status_summary rd");
    a_msr_loop: assert property (req.rd && req.addr == 3'h6 && norm
        && sel_n && cfg.loopback |=> rdata[7:4] == $past(loop_ms))
        else $error("looped msr");
    a_rsvd_write: assert property (req.wr && !req.rd && norm
        && req.addr == 3'h5 |=> $stable(cfg)) else $error("rsvd write");
endmodule

bind ucr_regmap ucr_regmap_assertions u_ucr_regmap_assertions (
    .mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
    .fifo_status_select_pin_n(fifo_status_select_pin_n), .stat(stat),
    .cfg(cfg), .hold_wr(hold_wr), .wr_data(wr_data), .rx_pop(rx_pop),
    .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .rts_n(rts_n), .dtr_n(dtr_n));
`default_nettype wire

// ===== tb/ucr_far_end.sv
// far side of the serial line and modem pins
// assumes the bench chooses the modem levels it wants
`timescale 1ns/10ps
`default_nettype none
module ucr_far_end (
    input wire logic mclk,
    input wire logic loopback,
    input wire logic [3:0] modem_set,
    output logic rx_pin,
    output ucr_pkg::ucr_modem_pins_t modem_pins
);
    import ucr_pkg::*;
    logic idle_q = 1'b0;
    // toggling line so a stale level never passes for data
    always @(posedge mclk) begin
        idle_q <= ~idle_q;
        modem_pins <= modem_set;
    end
    assign rx_pin = loopback ? 1'b1 : idle_q;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the uart channel register map
// assumes design, checker and far end model compiled before
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ucr_pkg::*;
    localparam logic [7:0] REV = 8'h3c; // arbitrary value
    localparam logic [7:0] DID = 8'hc3; // arbitrary value
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic fsel_n = 1'b1;
    logic tx_so = 1'b0;
    logic [3:0] mset = 4'hf;
    ucr_req_t req = '0;
    ucr_stat_t stat = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    ucr_cfg_t cfg;
    ucr_modem_pins_t mpins;
    logic [7:0] rdata;
    logic [7:0] wr_data;
    logic hold_wr, fcr_wr, trg_wr, ems_wr, rx_pop, lsr_rd;
    logic rx_si, tx_pin, rx_pin, rts_n, dtr_n, op1_n, op2_n;
    int err_count = 0;
    int checks_done = 0;

    initial begin
        forever #50 mclk = ~mclk;
    end

    ucr_regmap #(.REV_CODE(REV), .DEV_ID(DID)) u_ucr_regmap (
        .mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
        .fifo_status_select_pin_n(fsel_n), .stat(stat), .cfg(cfg),
        .hold_wr(hold_wr), .fifo_control_wr(fcr_wr),
        .trigger_wr(trg_wr), .mode_select_wr(ems_wr),
        .wr_data(wr_data), .rx_pop(rx_pop), .line_status_rd(lsr_rd),
        .tx_shift_out(tx_so), .rx_shift_in(rx_si), .tx_pin(tx_pin),
        .rx_pin(rx_pin), .modem_pins(mpins), .rts_n(rts_n),
        .dtr_n(dtr_n), .op1_n(op1_n), .op2_n(op2_n));

    ucr_far_end u_ucr_far_end (.mclk(mclk), .loopback(cfg.loopback),
        .modem_set(mset), .rx_pin(rx_pin), .modem_pins(mpins));

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] got,
        input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // strobes stay up after the edge; idle or a following rd call lowers them
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        req.rd = 1'b0;
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge mclk);
        #1;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp,
        input string what);
        req.wr = 1'b0;
        req.rd = 1'b1;
        req.addr = a;
        @(posedge mclk);
        #1;
        chk(what, rdata, exp);
    endtask

    task automatic idle(input int n);
        req.rd = 1'b0;
        req.wr = 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask

    initial begin
        repeat (3000) @(posedge mclk);
        err_count++;
        $display("BAD watchdog expected finish seen hang");
        results();
    end

    initial begin
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        idle(2);
        rd(3'h3, 8'h00, "lcr reset");
        chk("loop reset", cfg.loopback, 1'b0);
        wr(3'h1, 8'h5a);
        wr(3'h7, 8'ha5);
        wr(3'h5, 8'hff);
        wr(3'h6, 8'hff);
        rd(3'h1, 8'h5a, "ier");
        rd(3'h7, 8'ha5, "spr");
        rd(3'h2, 8'h22, "isr");
        rd(3'h5, 8'h33, "lsr");
        chk("lsr pulse", lsr_rd, 1'b1);
        rd(3'h0, 8'h11, "rhr");
        chk("pop", rx_pop, 1'b1);
        wr(3'h0, 8'h9c);
        chk("hold pulse", hold_wr, 1'b1);
        chk("hold data", wr_data, 8'h9c);
        wr(3'h2, 8'h07);
        chk("fcr pulse", fcr_wr, 1'b1);
        $display("test normal done");
        wr(3'h3, 8'h80);
        rd(3'h0, REV, "rev");
        rd(3'h1, DID, "devid");
        rd(3'h2, 8'h00, "unmapped");
        wr(3'h0, 8'h0c);
        rd(3'h0, 8'h0c, "dll");
        rd(3'h1, 8'h00, "dlm");
        wr(3'h1, 8'h03);
        chk("divisor", cfg.divisor, 16'h030c);
        rd(3'h3, 8'h80, "lcr dlab");
        $display("test divisor done");
        wr(3'h3, 8'hbf);
        for (int i = 4; i < 8; i++) begin
            wr(i[2:0], 8'hb0 + 8'(i));
        end
        for (int i = 4; i < 8; i++) begin
            rd(i[2:0], 8'hb0 + 8'(i), "flow char");
        end
        chk("stop2", cfg.stop_char2, 8'hb7);
        chk("mcr kept", cfg.modem_control, 8'h00);
        wr(3'h1, 8'h40);
        wr(3'h2, 8'h10);
        rd(3'h1, 8'h40, "feature_control");
        rd(3'h2, 8'h10, "efr");
        rd(3'h0, 8'h55, "fc");
        wr(3'h0, 8'h21);
        chk("trg pulse", trg_wr, 1'b1);
        rd(3'h3, 8'hbf, "lcr key");
        $display("test enhanced done");
        wr(3'h3, 8'h03);
        rd(3'h7, 8'h44, "fifo_level_count");
        wr(3'h7, 8'h0f);
        chk("ems pulse", ems_wr, 1'b1);
        idle(1);
        fsel_n = 1'b0;
        rd(3'h0, 8'h66, "fifo_status_summary");
        chk("no pop", rx_pop, 1'b0);
        rd(3'h6, 8'h66, "fstat6");
        fsel_n = 1'b1;
        idle(2);
        $display("test status select done");
        rd(3'h6, 8'h00, "msr idle");
        mset = 4'he;
        idle(3);
        rd(3'h6, 8'h11, "msr cts");
        rd(3'h6, 8'h10, "msr clear");
        $display("test modem status done");
        wr(3'h4, 8'h13);
        idle(1);
        chk("loop on", cfg.loopback, 1'b1);
        chk("tx mark", tx_pin, 1'b1);
        chk("rts dtr off", {rts_n, dtr_n, op1_n, op2_n}, 4'hf);
        tx_so = 1'b1;
        idle(1);
        chk("loop rx1", rx_si, 1'b1);
        tx_so = 1'b0;
        mset = 4'h0;
        idle(3);
        chk("loop rx0", rx_si, 1'b0);
        rd(3'h6, 8'h32, "msr loop");
        rd(3'h6, 8'h30, "msr pins ignored");
        wr(3'h4, 8'h03);
        chk("rts dtr on", {rts_n, dtr_n}, 2'b00);
        chk("tx pass", tx_pin, tx_so);
        chk("rx pass", rx_si, rx_pin);
        mset = 4'hf;
        wr(3'h4, 8'h0f);
        chk("modem outs", {rts_n, dtr_n, op1_n, op2_n}, 4'h0);
        chk("wr strobes", {hold_wr, fcr_wr, trg_wr, ems_wr}, 4'h0);
        chk("rd strobes", {rx_pop, lsr_rd}, 2'b00);
        $display("test loopback done");
        rst = 1'b1;
        idle(2);
        rst = 1'b0;
        chk("rst cfg", {cfg.line_control, cfg.modem_control}, 16'h0);
        chk("rst pins", {rts_n, dtr_n, op1_n, op2_n}, 4'hf);
        chk("rst rdata", rdata, 8'h00);
        rd(3'h3, 8'h00, "lcr after reset");
        $display("test reset done");
        idle(2);
        results();
    end
endmodule
`default_nettype wire
